// *** include/csad_pkg.sv ***
`default_nettype none
package csad_pkg;
   // ---------------------------------------------------------------
   // Address patterns
   // ---------------------------------------------------------------
   localparam logic [3:0] MEM_UPPER = 4'hA;
   localparam logic [3:0] TS_UPPER_LOW = 4'h3;
   localparam logic [3:0] TS_UPPER_FLOAT = 4'h5;
   localparam logic [3:0] TS_UPPER_HIGH = 4'h9;
   localparam logic [3:0] RSVD_UPPER = 4'h0;
   localparam logic [2:0] TS_LOW_BASE_LOW = 3'h0;
   localparam logic [2:0] TS_LOW_BASE_FLOAT = 3'h1;
   localparam logic [2:0] TS_LOW_BASE_HIGH = 3'h4;
   localparam logic [2:0] TS_SLOT_STEP = 3'h2;
   // ---------------------------------------------------------------
   // Conversion rate
   // ---------------------------------------------------------------
   localparam logic [7:0] RATE_RESET = 8'h02;
   localparam logic [7:0] RATE_MAX = 8'h07;
   localparam int RATE_SLOWEST_MS = 16000;
   localparam int CLK_MHZ = 250;
   localparam longint SLOWEST_CYCLES = longint'(RATE_SLOWEST_MS) * 1000 * CLK_MHZ;
   // ---------------------------------------------------------------
   // Link timing
   // ---------------------------------------------------------------
   localparam int STOP_SETUP_NS = 4000;
   localparam int STOP_SETUP_CYC = (STOP_SETUP_NS + 3) / 4;
   typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_PASS, ST_SKIP} csad_state_e;
endpackage
`default_nettype wire

// *** rtl/csad_top.sv ***
// Function
// - In auto-convert mode, conversions start periodically at the selected rate.
// - Power-up loads conversion rate value 02h, nominally 0.25 Hz.
// - Actual conversion rate may deviate from nominal by up to 25 percent.
// - Memories answer only addresses whose upper four bits are 1010.
// - Address bit 1 selects scratch memory at 0, information ROM at 1.
// - Address bits 3 and 2 match the mid and low slot pins.
// - Address bit 0 is the direction and never selects a device.
// - Sensor upper pattern is 0011, 0101 or 1001 by tri-level pin.
// - Two-level pin adds two to the sensor's seven-bit address.
// - An undriven two-level slot pin reads as logic 0.
// - Rate values 0 to 7 give 0.0625 to 8 Hz; higher are reserved.
// - Standby bit clear means auto-convert; set stops converting at once.
`timescale 1ns/1ns
`default_nettype none
module csad_top
   import csad_pkg::*;
#(
   parameter longint SLOWEST_PERIOD = SLOWEST_CYCLES
)
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N_O,
   input wire logic SLOT_SELECT_LOW_I,
   input wire logic SLOT_SELECT_MID_I,
   input wire logic SLOT_SELECT_TRI_HIGH_I,
   input wire logic SLOT_SELECT_TRI_FLOAT_I,
   input wire logic STANDBY_I,
   input wire logic [7:0] RATE_I,
   input wire logic RATE_WE_I,
   output logic [7:0] RATE_O,
   output logic CONVERT_O,
   output logic MEM_SEL_O,
   output logic [2:0] MEM_INDEX_O,
   output logic ROM_SEL_O,
   output logic TS_SEL_O,
   output logic RW_O
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [6:0] meta_r;
   logic [6:0] sync_r;
   logic scl_d_r;
   logic sda_d_r;
   always_ff @(posedge CLK_I)
   begin
      meta_r <= {SCL_I, SDA_I, SLOT_SELECT_LOW_I, SLOT_SELECT_MID_I,
                 SLOT_SELECT_TRI_HIGH_I, SLOT_SELECT_TRI_FLOAT_I, STANDBY_I};
      sync_r <= meta_r;
   end
   wire logic scl = sync_r[6];
   wire logic sda = sync_r[5];
   // Pull-downs on the substrate make an undriven pin arrive low.
   wire logic slot_low = sync_r[4];
   wire logic slot_mid = sync_r[3];
   wire logic standby = sync_r[0];
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl;
         sda_d_r <= sda;
      end
   end
   wire logic scl_rise = scl & ~scl_d_r;
   wire logic scl_fall = ~scl & scl_d_r;
   wire logic start_ev = scl & scl_d_r & sda_d_r & ~sda;
   wire logic stop_ev = scl & scl_d_r & ~sda_d_r & sda;
   // ---------------------------------------------------------------
   // Own addresses
   // ---------------------------------------------------------------
   logic [3:0] ts_upper;
   logic [2:0] ts_lower;
   always_comb
   begin
      // Float wins only when the pin is neither driven high nor low.
      if (sync_r[1] && !sync_r[2])
      begin
         ts_upper = TS_UPPER_FLOAT;
         ts_lower = TS_LOW_BASE_FLOAT;
      end
      else if (sync_r[2])
      begin
         ts_upper = TS_UPPER_HIGH;
         ts_lower = TS_LOW_BASE_HIGH;
      end
      else
      begin
         ts_upper = TS_UPPER_LOW;
         ts_lower = TS_LOW_BASE_LOW;
      end
      if (slot_mid)
      begin
         ts_lower = ts_lower + TS_SLOT_STEP;
      end
   end
   // ---------------------------------------------------------------
   // Address byte receiver
   // ---------------------------------------------------------------
   csad_state_e state_r;
   logic [7:0] shift_r;
   logic [3:0] bit_cnt_r;
   logic ack_r;
   // Bit 0 is never compared, so both directions decode alike.
   wire logic mem_hit = shift_r[7:4] == MEM_UPPER && shift_r[3] == slot_mid
                        && shift_r[2] == slot_low;
   wire logic ts_hit = shift_r[7:4] == ts_upper && shift_r[3:1] == ts_lower;
   wire logic rsvd = shift_r[7:4] == RSVD_UPPER;
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         state_r <= ST_IDLE;
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         ack_r <= 1'b0;
         MEM_SEL_O <= 1'b0;
         ROM_SEL_O <= 1'b0;
         TS_SEL_O <= 1'b0;
         RW_O <= 1'b0;
         MEM_INDEX_O <= 3'h0;
      end
      else if (stop_ev)
      begin
         state_r <= ST_IDLE;
         ack_r <= 1'b0;
         MEM_SEL_O <= 1'b0;
         ROM_SEL_O <= 1'b0;
         TS_SEL_O <= 1'b0;
      end
      else if (start_ev)
      begin
         state_r <= ST_ADDR;
         bit_cnt_r <= 4'h0;
         ack_r <= 1'b0;
         MEM_SEL_O <= 1'b0;
         ROM_SEL_O <= 1'b0;
         TS_SEL_O <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_ADDR:
               if (scl_rise)
               begin
                  shift_r <= {shift_r[6:0], sda};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               else if (scl_fall && bit_cnt_r == 4'h8)
               begin
                  if (!rsvd && (mem_hit || ts_hit))
                  begin
                     state_r <= ST_ACK;
                     ack_r <= 1'b1;
                     MEM_SEL_O <= mem_hit;
                     ROM_SEL_O <= mem_hit & shift_r[1];
                     TS_SEL_O <= ts_hit;
                     RW_O <= shift_r[0];
                     MEM_INDEX_O <= shift_r[3:1];
                  end
                  else
                  begin
                     state_r <= ST_SKIP;
                  end
               end
            ST_ACK:
               if (scl_fall)
               begin
                  ack_r <= 1'b0;
                  state_r <= ST_PASS;
               end
            default:
               state_r <= state_r;
         endcase
      end
   end
   // Open drain: enable is low while pulling the line low.
   assign SDA_O = 1'b0;
   assign SDA_OE_N_O = ~ack_r;
   // ---------------------------------------------------------------
   // Conversion rate and timer
   // ---------------------------------------------------------------
   logic [7:0] rate_r;
   logic [63:0] tick_r;
   logic [63:0] period;
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         rate_r <= RATE_RESET;
      end
      else if (RATE_WE_I && RATE_I <= RATE_MAX)
      begin
         rate_r <= RATE_I;
      end
   end
   assign RATE_O = rate_r;
   // Nominal period halves per step; clock-exact is well inside the tolerance.
   assign period = SLOWEST_PERIOD[63:0] >> rate_r[2:0];
   always_ff @(posedge CLK_I)
   begin
      if (RST_I || standby)
      begin
         tick_r <= 64'h0000_0000_0000_0000;
         CONVERT_O <= 1'b0;
      end
      else if (tick_r + 64'h0000_0000_0000_0001 >= period)
      begin
         tick_r <= 64'h0000_0000_0000_0000;
         CONVERT_O <= 1'b1;
      end
      else
      begin
         tick_r <= tick_r + 64'h0000_0000_0000_0001;
         CONVERT_O <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_rate_reset;
      @(posedge CLK_I) $fell(RST_I) |-> rate_r == RATE_RESET;
   endproperty
   a_rate_reset: assert property (p_rate_reset) else $error("rate not default");
   property p_standby;
      @(posedge CLK_I) disable iff (RST_I) standby |=> !CONVERT_O;
   endproperty
   a_standby: assert property (p_standby) else $error("convert in standby");
   property p_rate_legal;
      @(posedge CLK_I) disable iff (RST_I) 1'b1 |-> rate_r <= RATE_MAX;
   endproperty
   a_rate_legal: assert property (p_rate_legal) else $error("reserved rate");
   property p_mem_upper;
      @(posedge CLK_I) disable iff (RST_I) $rose(MEM_SEL_O) |-> shift_r[7:4] == MEM_UPPER;
   endproperty
   a_mem_upper: assert property (p_mem_upper) else $error("bad memory upper");
   property p_rom_bit;
      @(posedge CLK_I) disable iff (RST_I) $rose(MEM_SEL_O) |-> ROM_SEL_O == shift_r[1];
   endproperty
   a_rom_bit: assert property (p_rom_bit) else $error("bad device select");
   property p_slot;
      @(posedge CLK_I) disable iff (RST_I)
         $rose(MEM_SEL_O) |-> MEM_INDEX_O[2:1] == {slot_mid, slot_low};
   endproperty
   a_slot: assert property (p_slot) else $error("slot mismatch");
   property p_ts_pattern;
      @(posedge CLK_I) disable iff (RST_I) $rose(TS_SEL_O) |-> shift_r[7:4] == ts_upper;
   endproperty
   a_ts_pattern: assert property (p_ts_pattern) else $error("bad sensor upper");
   property p_no_ack_miss;
      @(posedge CLK_I) disable iff (RST_I) state_r == ST_SKIP |-> SDA_OE_N_O;
   endproperty
   a_no_ack_miss: assert property (p_no_ack_miss) else $error("ack on miss");
   property p_ack_sel;
      @(posedge CLK_I) disable iff (RST_I) !SDA_OE_N_O |-> MEM_SEL_O || TS_SEL_O;
   endproperty
   a_ack_sel: assert property (p_ack_sel) else $error("ack without select");
   // A period of one cycle would hold the pulse high; the parameter keeps it far above that.
   property p_convert_once;
      @(posedge CLK_I) disable iff (RST_I)
         CONVERT_O |=> !CONVERT_O;
   endproperty
   a_convert_once: assert property (p_convert_once) else $error("long pulse");
   property p_rate_write;
      @(posedge CLK_I) disable iff (RST_I)
         RATE_WE_I && RATE_I <= RATE_MAX |=> rate_r == $past(RATE_I);
   endproperty
   a_rate_write: assert property (p_rate_write) else $error("rate not taken");
   property p_rate_hold;
      @(posedge CLK_I) disable iff (RST_I)
         RATE_WE_I && RATE_I > RATE_MAX |=> $stable(rate_r);
   endproperty
   a_rate_hold: assert property (p_rate_hold) else $error("rate changed");
   property p_ack_release;
      @(posedge CLK_I) disable iff (RST_I)
         state_r == ST_ACK && scl_fall |=> SDA_OE_N_O;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack held");
   property p_rw;
      @(posedge CLK_I) disable iff (RST_I)
         $rose(MEM_SEL_O) || $rose(TS_SEL_O) |-> RW_O == shift_r[0];
   endproperty
   a_rw: assert property (p_rw) else $error("bad direction");
   property p_ts_lower;
      @(posedge CLK_I) disable iff (RST_I)
         $rose(TS_SEL_O) |-> shift_r[3:1] == ts_lower;
   endproperty
   a_ts_lower: assert property (p_ts_lower) else $error("bad sensor slot");
   property p_no_rsvd;
      @(posedge CLK_I) disable iff (RST_I)
         $rose(MEM_SEL_O) || $rose(TS_SEL_O) |-> shift_r[7:4] != RSVD_UPPER;
   endproperty
   a_no_rsvd: assert property (p_no_rsvd) else $error("reserved claimed");
   property p_sel_ack;
      @(posedge CLK_I) disable iff (RST_I)
         $rose(MEM_SEL_O) || $rose(TS_SEL_O) |-> !SDA_OE_N_O;
   endproperty
   a_sel_ack: assert property (p_sel_ack) else $error("select without ack");
endmodule
`default_nettype wire

// *** testbench/csad_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module csad_host
(
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // ------------------------------------------------
   // Bus host model
   // ------------------------------------------------
   // Both lines idle high because the host drives them high at start and leaves them high at the end of each STOP.
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Sends START and one byte MSB first, then samples the ninth bit late in the high phase.
   task automatic addr(input logic [7:0] a, output logic ack);
      sda_o = 1'b0;
      #16 scl_o = 1'b0;
      for (int i = 7; i >= -1; i--)
      begin
         #8 sda_o = (i >= 0) ? a[i] : 1'b1;
         #8 scl_o = 1'b1;
         #15 ack = ~sda_i;
         #1 scl_o = 1'b0;
      end
   endtask
   task automatic stop();
      #8 sda_o = 1'b0;
      #8 scl_o = 1'b1;
      #(csad_pkg::STOP_SETUP_NS) sda_o = 1'b1;
      #100;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ------------------------------------------------
   // Bench
   // ------------------------------------------------
   logic clk, rst, scl, h_sda, sda_o, oe_n, lo, mid, tri_h, tri_f, stby, rate_we;
   logic conv, mem_sel, rom_sel, ts_sel, rw;
   logic [7:0] rate, rate_o;
   logic [2:0] mem_idx;
   wire sda = h_sda & (oe_n | sda_o);
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   csad_host i_host (.sda_i(sda), .scl_o(scl), .sda_o(h_sda));
   csad_top #(.SLOWEST_PERIOD(1024)) i_dut (.CLK_I(clk), .RST_I(rst), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(oe_n), .SLOT_SELECT_LOW_I(lo),
      .SLOT_SELECT_MID_I(mid), .SLOT_SELECT_TRI_HIGH_I(tri_h),
      .SLOT_SELECT_TRI_FLOAT_I(tri_f), .STANDBY_I(stby), .RATE_I(rate),
      .RATE_WE_I(rate_we), .RATE_O(rate_o), .CONVERT_O(conv), .MEM_SEL_O(mem_sel),
      .MEM_INDEX_O(mem_idx), .ROM_SEL_O(rom_sel), .TS_SEL_O(ts_sel), .RW_O(rw));
   always #2 clk = ~clk;
   task automatic final_report();
      $display("compared=%0d miscompares=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A hang costs 90000 cycles, only some 20000 more than the roughly 70000 cycles the tests need.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Expected flags are {ack, memory, rom, sensor}.
   task automatic frame(input logic [7:0] a, input logic [3:0] exp);
      logic ack;
      @(negedge clk);
      i_host.addr(a, ack);
      chk({4'h0, ack, mem_sel, rom_sel, ts_sel}, {4'h0, exp});
      if (ack)
         chk({7'h0, rw}, {7'h0, a[0]});
      i_host.stop();
   endtask
   task automatic mem_scan();
      logic m;
      for (int s = 0; s < 4; s++)
      begin
         @(negedge clk);
         {mid, lo} = s[1:0]; // slot 0 models the pull-down level
         frame({4'hE, s[1:0], 2'b00}, 4'b0000);
         for (int a = 0; a < 8; a++)
         begin
            m = (a[2:1] == s[1:0]);
            frame({4'hA, a[2:0], a[0] ^ s[0]}, {m, m, m & a[0], 1'b0});
            if (m)
               chk({5'h0, mem_idx}, {5'h0, a[2:0]});
         end
      end
   endtask
   task automatic ts_scan();
      logic [3:0] up;
      logic [2:0] base;
      for (int t = 0; t < 6; t++)
      begin
         @(negedge clk);
         tri_h = (t >= 4);
         tri_f = (t == 2 || t == 3);
         mid = t[0];
         up = tri_h ? 4'h9 : tri_f ? 4'h5 : 4'h3;
         base = (tri_h ? 3'h4 : tri_f ? 3'h1 : 3'h0) + (mid ? 3'h2 : 3'h0);
         frame({up, base, t[1]}, 4'b1001);
         frame({up, base ^ 3'h2, 1'b0}, 4'b0000);
         frame({up ^ 4'hC, base, 1'b1}, 4'b0000);
      end
      frame(8'h0A, 4'b0000);
   endtask
   task automatic wait_conv(output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end while (conv !== 1'b1 && n < 3000);
   endtask
   task automatic rate_scan();
      int n;
      logic ok;
      for (int r = 0; r < 9; r++)
      begin
         @(negedge clk);
         rate = r[7:0];
         rate_we = 1'b1;
         @(negedge clk);
         rate_we = 1'b0;
         chk(rate_o, (r < 8) ? r[7:0] : 8'h07);
         wait_conv(n);
         wait_conv(n);
         ok = n * 4 >= 3 * (1024 >> r) && n * 4 <= 5 * (1024 >> r);
         chk({7'h0, ok}, {7'h0, r < 8});
      end
      stby = 1'b1;
      wait_conv(n);
      chk({7'h0, n == 3000}, 8'h01);
      stby = 1'b0;
   endtask
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      {lo, mid, tri_h, tri_f, stby, rate_we} = 6'h00;
      rate = 8'h00;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(rate_o, 8'h02);
      chk({4'h0, oe_n, mem_sel, rom_sel, ts_sel}, 8'h08);
      mem_scan();
      ts_scan();
      rate_scan();
      final_report();
   end
endmodule
`default_nettype wire
